// ==== test_timer_watchdog_counter.sv ====
// self-checking bench for the timer/watchdog counter
`timescale 1ns/10ps
`default_nettype none
`include "twd_defs.vh"
module test_timer_watchdog_counter;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic alt = 1;
   logic pin_run = 0;
   logic pin_idle = 1;
   logic ext0 = 0;
   logic err, pready, pslverr, tout, top_irq, irq_a0, sys_reset_req, cin;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   int n_errors = 0;
   int samples_checked = 0;
   int n_rst = 0;
   int cyc = 0;
   always #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (sys_reset_req === 1'b1)
         n_rst <= n_rst + 1;
   end
   twd_timer DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_input_pin(cin), .ext_irq_zero_pin(ext0),
      .hw_sw_watch_select_pin(1'b1), .other_alt_out(alt), .timer_output_pin(tout),
      .top_irq(top_irq), .irq_a0(irq_a0), .sys_reset_req(sys_reset_req));
   twd_partner P (.pclk(pclk), .run(pin_run), .idle(pin_idle), .count_input_pin(cin));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic period(input string nm, input int exp);
      int t0;
      logic v;
      @(posedge pclk);
      v = tout;
      while (tout === v) @(posedge pclk);
      t0 = cyc;
      v = tout;
      while (tout === v) @(posedge pclk);
      chk(nm, cyc - t0, exp);
   endtask
   task automatic held(input string nm);
      logic [31:0] s;
      apb(0, `TWD_OFS_STATUS, 0);
      s = rd;
      repeat (16) @(posedge pclk);
      apb(0, `TWD_OFS_STATUS, 0);
      chk(nm, rd, s);
   endtask
   task automatic t_reset;
      logic [31:0] e [6] = '{32'hff, 32'hff, 32'hff, 32'h12, 32'h1, 32'hffffff};
      for (int i = 0; i < 6; i++) begin
         apb(0, 8'(4 * i), 0);
         chk("reset value", rd, e[i]);
      end
      apb(0, 8'h18, 0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      alt <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("shared out", tout, 0);
      alt <= 1'b1;
   endtask
   task automatic t_cont;
      apb(1, `TWD_OFS_HIGH, 0);
      apb(1, `TWD_OFS_LOW, 3);
      apb(1, `TWD_OFS_PRESCALE, 1);
      apb(1, `TWD_OFS_CTRL, 32'h81);
      period("wave prescaled", 32);
      apb(1, `TWD_OFS_PRESCALE, 0);
      period("wave new prescale", 16);
      apb(1, `TWD_OFS_CTRL, 32'h01);
      held("stopped");
   endtask
   task automatic t_single;
      apb(1, `TWD_OFS_CTRL, 32'hc1);
      repeat (60) @(posedge pclk);
      apb(0, `TWD_OFS_CTRL, 0);
      chk("single run clear", rd, 32'h41);
      apb(0, `TWD_OFS_STATUS, 0);
      chk("single reload", rd[15:0], 3);
      apb(1, `TWD_OFS_LOW, 9);
      apb(0, `TWD_OFS_STATUS, 0);
      chk("stopped load", rd[15:0], 9);
      apb(1, `TWD_OFS_LOW, 3);
   endtask
   task automatic t_event;
      pin_run <= 1'b1;
      apb(1, `TWD_OFS_CTRL, 32'h89);
      period("event wave", 32);
   endtask
   task automatic t_gated;
      pin_run <= 1'b0;
      pin_idle <= 1'b0;
      apb(1, `TWD_OFS_CTRL, 32'h99);
      held("gate low");
      pin_idle <= 1'b1;
      period("gate high", 16);
   endtask
   task automatic t_trig;
      apb(1, `TWD_OFS_CTRL, 32'h29);
      apb(1, `TWD_OFS_CTRL, 32'ha9);
      held("no trigger");
      pin_run <= 1'b1;
      period("triggered", 16);
      apb(1, `TWD_OFS_CTRL, 32'hb9);
      repeat (16) @(posedge pclk);
      rd[0] = tout;
      repeat (64) @(posedge pclk);
      chk("retriggered", tout, rd[0]);
   endtask
   task automatic t_irq;
      int nt = 0;
      int na = 0;
      apb(1, `TWD_OFS_CTRL, 32'h81);
      repeat (20) @(posedge pclk);
      repeat (64) begin
         @(posedge pclk);
         nt += (top_irq === 1'b1);
         na += (irq_a0 === 1'b1);
      end
      chk("top eoc pulses", nt, 4);
      chk("a0 eoc pulses", na, 4);
      apb(1, `TWD_OFS_CFG, 32'h7);
      ext0 <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("top ext pin", top_irq, 1);
      chk("a0 ext pin", irq_a0, 1);
      ext0 <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("top ext low", top_irq, 0);
   endtask
   task automatic t_watch;
      int r0;
      pin_run <= 1'b0;
      apb(1, `TWD_OFS_CTRL, 32'h00);
      apb(1, `TWD_OFS_CFG, 32'h0);
      repeat (40) @(posedge pclk);
      chk("watch expiry", n_rst > 0, 1);
      apb(1, `TWD_OFS_LOW, `TWD_SVC_FIRST);
      apb(1, `TWD_OFS_LOW, `TWD_SVC_SECOND);
      repeat (2) @(posedge pclk);
      r0 = n_rst;
      repeat (5) begin
         apb(1, `TWD_OFS_LOW, `TWD_SVC_FIRST);
         apb(1, `TWD_OFS_LOW, `TWD_SVC_SECOND);
      end
      chk("serviced", n_rst, r0);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_cont();
      t_single();
      t_event();
      t_gated();
      t_trig();
      t_irq();
      t_watch();
      close_out();
   end
endmodule
bind twd_timer twd_asserts A (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
   .pslverr, .other_alt_out, .timer_output_pin, .sys_reset_req);
`default_nettype wire

// ==== twd_asserts.sv ====
// concurrent checks on the timer/watchdog ports
`timescale 1ns/10ps
`default_nettype none
module twd_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic other_alt_out,
   input wire logic timer_output_pin,
   input wire logic sys_reset_req
);
   logic wr_seen;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wr_seen <= 1'b0;
      else if (psel && pwrite)
         wr_seen <= 1'b1;
   end
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   sequence s_pulse;
      pready ##1 !pready;
   endsequence
   a_ready_access: assert property (s_setup |-> pready) else $error("no ready in access");
   a_ready_single: assert property (pready |-> s_pulse) else $error("ready too long");
   a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
   a_rd_upper: assert property (pready && !pwrite |-> prdata[31:24] == 8'h0)
      else $error("upper read bits set");
   a_rst_pulse: assert property (sys_reset_req |=> !sys_reset_req)
      else $error("reset request too long");
   a_out_and: assert property (!other_alt_out |=> !timer_output_pin)
      else $error("shared output not anded");
   a_out_idle: assert property (!wr_seen && !psel && other_alt_out |=> timer_output_pin)
      else $error("disabled output not high");
endmodule
`default_nettype wire

// ==== twd_defs.vh ====
// register map, field positions and reset values of the timer/watchdog
`ifndef TWD_DEFS_VH
`define TWD_DEFS_VH
`define TWD_AW 8
`define TWD_OFS_HIGH 8'h00
`define TWD_OFS_LOW 8'h04
`define TWD_OFS_PRESCALE 8'h08
`define TWD_OFS_CTRL 8'h0c
`define TWD_OFS_CFG 8'h10
`define TWD_OFS_STATUS 8'h14
`define TWD_RST_HIGH 8'hff
`define TWD_RST_LOW 8'hff
`define TWD_RST_PRESCALE 8'hff
`define TWD_RST_CTRL 8'h12
`define TWD_RST_CFG 3'h1
`define TWD_CTRL_RUN 7
`define TWD_CTRL_SINGLE 6
`define TWD_CTRL_MODE_HI 5
`define TWD_CTRL_MODE_LO 4
`define TWD_CTRL_INPUT_ENABLE_BIT 3
`define TWD_CTRL_OUTPUT_MODE_BIT 2
`define TWD_CTRL_LEVEL 1
`define TWD_CTRL_OUTPUT_ENABLE_BIT 0
`define TWD_CFG_WATCH_EN 0
`define TWD_CFG_A0_SEL 1
`define TWD_CFG_TOP_SEL 2
`define TWD_MODE_EVENT 2'h0
`define TWD_MODE_GATED 2'h1
`define TWD_MODE_TRIG 2'h2
`define TWD_MODE_RETRIG 2'h3
`define TWD_CORE_DIV 4
`define TWD_SVC_FIRST 8'haa
`define TWD_SVC_SECOND 8'h55
`endif

// ==== twd_partner.sv ====
// external count source driving the timer input pin
`timescale 1ns/10ps
`default_nettype none
module twd_partner #(parameter int HALF = 4) (
   input wire logic pclk,
   input wire logic run,
   input wire logic idle,
   output logic count_input_pin
);
   int n = 0;
   logic lvl = 1'b1;
   always @(posedge pclk) begin
      if (!run) begin
         n <= 0;
         lvl <= 1'b1;
      end else if (n == HALF - 1) begin
         n <= 0;
         lvl <= ~lvl;
      end else begin
         n <= n + 1;
      end
   end
   assign count_input_pin = run ? lvl : idle;
endmodule
`default_nettype wire

// ==== twd_timer.v ====
// timer/watchdog counter with apb register slave
`timescale 1ns/10ps
`default_nettype none
`include "twd_defs.vh"
module twd_timer (
   input wire pclk,
   input wire presetn,
   input wire [`TWD_AW-1:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire count_input_pin,
   input wire ext_irq_zero_pin,
   input wire hw_sw_watch_select_pin,
   input wire other_alt_out,
   output reg timer_output_pin,
   output reg top_irq,
   output reg irq_a0,
   output reg sys_reset_req
);
   reg [7:0] count_high_reg;
   reg [7:0] count_low_reg;
   reg [7:0] prescale_reg;
   reg [7:0] timer_control_reg;
   reg [2:0] cfg_reg;
   reg [15:0] cnt_reg;
   reg [7:0] pre_cnt_reg;
   reg [1:0] div_reg;
   reg pin_prev_reg;
   reg armed_reg;
   reg wd_active_reg;
   reg hw_wd_reg;
   reg strap_done_reg;
   reg svc_armed_reg;
   reg wave_reg;
   reg hit;
   reg [31:0] rd_mux;
   reg step;
   wire [15:0] constant;
   wire run_bit;
   wire [1:0] in_mode;
   wire tick;
   wire fall;
   wire wr;
   wire wr_high;
   wire wr_low;
   wire wr_pre;
   wire wr_ctrl;
   wire wr_cfg;
   wire const_wr;
   wire main_step;
   wire eoc;
   wire svc_reload;
   wire retrig_reload;
   wire timer_eoc;

   assign constant = {count_high_reg, count_low_reg};
   assign run_bit = timer_control_reg[`TWD_CTRL_RUN];
   assign in_mode = timer_control_reg[`TWD_CTRL_MODE_HI:`TWD_CTRL_MODE_LO];
   // core clock divided by four
   assign tick = ({30'h0, div_reg} == (`TWD_CORE_DIV - 1));
   assign fall = pin_prev_reg & ~count_input_pin;

   // address decode and read data
   always @* begin
      hit = 1'b1;
      rd_mux = 32'h0;
      case (paddr)
         `TWD_OFS_HIGH: rd_mux = {24'h0, count_high_reg};
         `TWD_OFS_LOW: rd_mux = {24'h0, count_low_reg};
         `TWD_OFS_PRESCALE: rd_mux = {24'h0, prescale_reg};
         `TWD_OFS_CTRL: rd_mux = {24'h0, timer_control_reg};
         `TWD_OFS_CFG: rd_mux = {28'h0, wd_active_reg, cfg_reg};
         `TWD_OFS_STATUS: rd_mux = {8'h0, pre_cnt_reg, cnt_reg};
         default: hit = 1'b0;
      endcase
   end

   // no wait state: ready raised in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & ~penable;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= ~hit;
      end else begin
         pslverr <= 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         prdata <= hit ? rd_mux : 32'h0;
      end
   end

   assign wr = psel & penable & pready & pwrite;
   assign wr_high = wr && (paddr == `TWD_OFS_HIGH);
   assign wr_low = wr && (paddr == `TWD_OFS_LOW);
   assign wr_pre = wr && (paddr == `TWD_OFS_PRESCALE);
   assign wr_ctrl = wr && (paddr == `TWD_OFS_CTRL);
   assign wr_cfg = wr && (paddr == `TWD_OFS_CFG);
   assign const_wr = (wr_high | wr_low) & ~wd_active_reg;

   always @* begin
      step = 1'b0;
      if (wd_active_reg) begin
         step = tick;
      end else if (!run_bit) begin
         step = 1'b0;
      end else if (!timer_control_reg[`TWD_CTRL_INPUT_ENABLE_BIT]) begin
         step = tick;
      end else begin
         case (in_mode)
            `TWD_MODE_EVENT: step = fall;
            `TWD_MODE_GATED: step = tick & count_input_pin;
            `TWD_MODE_TRIG: step = tick & armed_reg;
            `TWD_MODE_RETRIG: step = tick;
            default: step = 1'b0;
         endcase
      end
   end

   assign main_step = step && (pre_cnt_reg == 8'h00);
   assign eoc = main_step && (cnt_reg == 16'h0000);
   assign timer_eoc = eoc & ~wd_active_reg;
   // second byte of the service pair
   assign svc_reload = wd_active_reg & wr_low & svc_armed_reg &
                       (pwdata[7:0] == `TWD_SVC_SECOND);
   assign retrig_reload = ~wd_active_reg & run_bit &
                          timer_control_reg[`TWD_CTRL_INPUT_ENABLE_BIT] &
                          (in_mode == `TWD_MODE_RETRIG) & fall;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end

   // previous pin level for edge detection
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev_reg <= 1'b1;
      end else begin
         pin_prev_reg <= count_input_pin;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_reg <= 1'b0;
      end else if (!run_bit) begin
         armed_reg <= 1'b0;
      end else if (fall) begin
         armed_reg <= 1'b1;
      end
   end

   // constant high byte
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_high_reg <= `TWD_RST_HIGH;
      end else if (wr_high && !wd_active_reg) begin
         count_high_reg <= pwdata[7:0];
      end
   end

   // constant low byte
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_low_reg <= `TWD_RST_LOW;
      end else if (wr_low && !wd_active_reg) begin
         count_low_reg <= pwdata[7:0];
      end
   end

   // prescaler code
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_reg <= `TWD_RST_PRESCALE;
      end else if (wr_pre) begin
         prescale_reg <= pwdata[7:0];
      end
   end

   // configuration bits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= `TWD_RST_CFG;
      end else begin
         if (wr_cfg) begin
            // watch enable bit can only be cleared
            cfg_reg[`TWD_CFG_WATCH_EN] <= cfg_reg[`TWD_CFG_WATCH_EN] &
                                          pwdata[`TWD_CFG_WATCH_EN];
            cfg_reg[`TWD_CFG_A0_SEL] <= pwdata[`TWD_CFG_A0_SEL];
            cfg_reg[`TWD_CFG_TOP_SEL] <= pwdata[`TWD_CFG_TOP_SEL];
         end
      end
   end

   // control register with hardware run clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control_reg <= `TWD_RST_CTRL;
      end else if (wr_ctrl) begin
         // mode and run in one write
         timer_control_reg <= pwdata[7:0];
      end else if (timer_eoc && timer_control_reg[`TWD_CTRL_SINGLE]) begin
         timer_control_reg[`TWD_CTRL_RUN] <= 1'b0;
      end
   end

   // watchdog entry: strap after reset or software clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_active_reg <= 1'b0;
         hw_wd_reg <= 1'b0;
         strap_done_reg <= 1'b0;
      end else begin
         strap_done_reg <= 1'b1;
         if (!strap_done_reg && !hw_sw_watch_select_pin) begin
            wd_active_reg <= 1'b1;
            hw_wd_reg <= 1'b1;
         end else if (wr_cfg && !pwdata[`TWD_CFG_WATCH_EN]) begin
            wd_active_reg <= 1'b1;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         svc_armed_reg <= 1'b0;
      end else if (wr_low) begin
         svc_armed_reg <= (pwdata[7:0] == `TWD_SVC_FIRST);
      end
   end

   // prescaler divides by code plus one
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_reg <= `TWD_RST_PRESCALE;
      end else if (svc_reload || retrig_reload) begin
         pre_cnt_reg <= prescale_reg;
      end else if (wr_pre) begin
         pre_cnt_reg <= pwdata[7:0];
      end else if (step) begin
         pre_cnt_reg <= (pre_cnt_reg == 8'h00) ? prescale_reg : pre_cnt_reg - 8'h01;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= {`TWD_RST_HIGH, `TWD_RST_LOW};
      end else if (svc_reload || retrig_reload) begin
         cnt_reg <= constant;
      end else if (const_wr && !run_bit) begin
         // new constant while stopped is loaded
         if (wr_high) begin
            cnt_reg <= {pwdata[7:0], count_low_reg};
         end else begin
            cnt_reg <= {count_high_reg, pwdata[7:0]};
         end
      end else if (eoc) begin
         cnt_reg <= constant;
      end else if (main_step) begin
         cnt_reg <= cnt_reg - 16'h0001;
      end
   end

   // output wave: square toggles, pwm copies level
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_reg <= 1'b1;
      end else if (timer_eoc) begin
         if (timer_control_reg[`TWD_CTRL_OUTPUT_MODE_BIT]) begin
            wave_reg <= timer_control_reg[`TWD_CTRL_LEVEL];
         end else begin
            // toggle at each end of count
            wave_reg <= ~wave_reg;
         end
      end
   end

   // disabled output high, anded with others
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_output_pin <= 1'b1;
      end else begin
         timer_output_pin <= (timer_control_reg[`TWD_CTRL_OUTPUT_ENABLE_BIT] ? wave_reg : 1'b1) &
                             other_alt_out;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         top_irq <= 1'b0;
      end else begin
         top_irq <= cfg_reg[`TWD_CFG_TOP_SEL] ? ext_irq_zero_pin : timer_eoc;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_a0 <= 1'b0;
      end else begin
         irq_a0 <= cfg_reg[`TWD_CFG_A0_SEL] ? ext_irq_zero_pin : timer_eoc;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_reset_req <= 1'b0;
      end else begin
         sys_reset_req <= eoc & wd_active_reg;
      end
   end
endmodule
`default_nettype wire
